/* File: acc_pkg.sv */
package acc_pkg;

    // register byte offsets on the bus, one aligned word each
    localparam logic [7:0] OFS_CTRL0    = 8'h00;  // converter_control_0
    localparam logic [7:0] OFS_CTRL1    = 8'h04;  // converter_control_1
    localparam logic [7:0] OFS_RES_HIGH = 8'h08;  // result_high
    localparam logic [7:0] OFS_RES_LOW  = 8'h0c;  // result_low
    localparam logic [7:0] OFS_IRQ      = 8'h10;  // interrupt enables and request flag

    // converter_control_0 field positions
    localparam int BIT_START    = 7;   // start bit, conversion on its falling edge
    localparam int BIT_BUSY     = 6;   // conversion_busy_flag, read only
    localparam int BIT_POWER    = 5;   // converter_power_on
    localparam int BIT_FORMAT   = 4;   // result_format_sel
    localparam int CHAN_LSB     = 0;   // ext_channel_sel lowest bit
    localparam int CHAN_W       = 4;   // ext_channel_sel width

    // converter_control_1 field positions
    localparam int SRC_LSB      = 5;   // input_source_sel lowest bit
    localparam int SRC_W        = 3;   // input_source_sel width
    localparam int VREF_LSB     = 3;   // vref_source_sel lowest bit
    localparam int VREF_W       = 2;   // vref_source_sel width
    localparam int DIV_LSB      = 0;   // clock_div_sel lowest bit
    localparam int DIV_W        = 3;   // clock_div_sel width

    // interrupt register field positions
    localparam int BIT_GIE      = 0;   // global_irq_enable
    localparam int BIT_CIE      = 1;   // conv_irq_enable
    localparam int BIT_FLAG     = 2;   // conv_irq_flag

    // values after reset
    localparam logic [7:0] CTRL0_RST    = 8'h00;
    localparam logic [7:0] CTRL1_RST    = 8'h00;
    localparam logic [2:0] IRQ_RST      = 3'h0;

    // input source code that routes the external channel to the converter
    localparam logic [SRC_W-1:0] SRC_EXTERNAL = 3'h0;

    // conversion timing in conversion clock periods
    localparam int SAMPLE_TICKS  = 4;
    localparam int CONVERT_TICKS = 12;
    localparam int RES_W         = 12;  // result width, full scale 12'hfff

    // conversion sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONVERT
    } acc_state_t;

endpackage : acc_pkg

/* File: acc_clkdiv.sv */
`timescale 1ns/1ns
// conversion clock enable: one pulse every 2**sel system clocks
module acc_clkdiv #(
    parameter int SEL_W = 3
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    // control
    input  wire logic             i_clear,  // hold count at zero, no pulse
    input  wire logic [SEL_W-1:0] i_sel,    // division exponent
    // enable out
    output logic                  o_tick    // one-cycle conversion clock enable
);

    localparam int CNT_W = (2 ** SEL_W) - 1;  // wide enough for the largest ratio

    logic [CNT_W-1:0] cnt_reg;   // cycles since last pulse
    logic [CNT_W-1:0] cnt_next;
    logic [CNT_W-1:0] terminal;  // last count before the pulse

    // code 0 gives a pulse every cycle, each step doubles the period
    always_comb begin
        terminal = CNT_W'((CNT_W+1)'(1) << i_sel) - CNT_W'(1);
        o_tick   = !i_clear && (cnt_reg == terminal);
        if (i_clear || o_tick) begin
            cnt_next = '0;
        end else begin
            cnt_next = cnt_reg + CNT_W'(1);
        end
    end

    // count register
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

endmodule : acc_clkdiv

/* File: acc_top.sv */
// Implementation choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ns
module acc_top (
    // clock and reset
    input  wire logic                                I_CLK,
    input  wire logic                                I_RSTN,
    // ahb-lite slave
    input  wire logic                                I_HSEL,
    input  wire logic [31:0]                         I_HADDR,
    input  wire logic [1:0]                          I_HTRANS,
    input  wire logic                                I_HWRITE,
    input  wire logic [2:0]                          I_HSIZE,
    input  wire logic [31:0]                         I_HWDATA,
    input  wire logic                                I_HREADY,
    output logic [31:0]                              O_HRDATA,
    output logic                                     O_HREADYOUT,
    output logic                                     O_HRESP,
    // analog converter side
    input  wire logic                                I_CMP_ABOVE,   // input above trial level
    output logic                                     O_ADC_POWER,
    output logic                                     O_ADC_RESET,
    output logic                                     O_ADC_SAMPLE,
    output logic [acc_pkg::RES_W-1:0]                O_DAC_CODE,
    output logic [acc_pkg::SRC_W-1:0]                O_INPUT_SRC,
    output logic [acc_pkg::CHAN_W-1:0]               O_EXT_CHANNEL,
    output logic                                     O_EXT_CONNECT,
    output logic [acc_pkg::VREF_W-1:0]               O_VREF_SRC,
    // status to the processor
    output logic                                     O_BUSY,
    output logic                                     O_CONV_IRQ
);

    // split the result into high and low byte views by format
    function automatic logic [15:0] format_result(input logic [acc_pkg::RES_W-1:0] res, input logic fmt);
        if (fmt) begin
            format_result = {4'h0, res[11:8], res[7:0]};  // right aligned
        end else begin
            format_result = {res[11:4], res[3:0], 4'h0};  // left aligned
        end
    endfunction : format_result

    // bus state
    logic       wr_pend_reg;   // write data phase pending
    logic       wr_pend_next;
    logic       rd_pend_reg;   // read data phase pending
    logic       rd_pend_next;
    logic [7:0] addr_reg;      // latched byte offset
    logic [7:0] addr_next;
    logic       accept;        // address phase taken this cycle

    // software registers
    logic [7:0] ctrl0_reg;     // start, power, format, channel (busy not stored)
    logic [7:0] ctrl0_next;
    logic [7:0] ctrl1_reg;     // source, reference, divider
    logic [7:0] ctrl1_next;
    logic [2:0] irq_reg;       // flag, converter enable, global enable
    logic [2:0] irq_next;
    logic       start_q_reg;   // start bit one cycle ago
    logic       start_q_next;

    // conversion state
    acc_pkg::acc_state_t           state_reg;
    acc_pkg::acc_state_t           state_next;
    logic [3:0]                    cnt_reg;      // sampling periods seen
    logic [3:0]                    cnt_next;
    logic [3:0]                    bit_reg;      // bit under trial
    logic [3:0]                    bit_next;
    logic [acc_pkg::RES_W-1:0]     sar_reg;      // approximation so far
    logic [acc_pkg::RES_W-1:0]     sar_next;
    logic [acc_pkg::RES_W-1:0]     result_reg;   // last completed result
    logic [acc_pkg::RES_W-1:0]     result_next;
    logic                          busy_reg;
    logic                          busy_next;
    logic                          done;         // completion pulse
    logic                          launch;       // start falling edge seen
    logic                          hold;         // converter held off or in reset
    logic                          tick;         // conversion clock enable
    logic [15:0]                   view;         // formatted result

    // field views
    logic start_bit;
    logic power_bit;
    logic fmt_bit;
    assign start_bit = ctrl0_reg[acc_pkg::BIT_START];
    assign power_bit = ctrl0_reg[acc_pkg::BIT_POWER];
    assign fmt_bit   = ctrl0_reg[acc_pkg::BIT_FORMAT];

    // conversion clock divider, restarted while idle so every conversion
    // sees whole periods from its launch
    acc_clkdiv #(
        .SEL_W (acc_pkg::DIV_W)
    ) u_div (
        .i_clk   (I_CLK),
        .i_rstn  (I_RSTN),
        .i_clear (state_reg == acc_pkg::ST_IDLE),
        .i_sel   (ctrl1_reg[acc_pkg::DIV_LSB +: acc_pkg::DIV_W]),
        .o_tick  (tick)
    );

    // bus: zero wait states, always okay; unmapped offsets read zero
    always_comb begin
        accept       = I_HSEL && I_HTRANS[1] && I_HREADY;
        wr_pend_next = accept && I_HWRITE;
        rd_pend_next = accept && !I_HWRITE;
        addr_next    = accept ? I_HADDR[7:0] : addr_reg;
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg    <= 8'h00;
        end else begin
            wr_pend_reg <= wr_pend_next;
            rd_pend_reg <= rd_pend_next;
            addr_reg    <= addr_next;
        end
    end

    // read mux from registered offset; values are taken straight from the
    // register flops so a write just before is visible
    always_comb begin
        view     = format_result(result_reg, fmt_bit);
        O_HRDATA = 32'h0000_0000;
        if (rd_pend_reg) begin
            case (addr_reg)
                acc_pkg::OFS_CTRL0: begin
                    O_HRDATA[7:0]               = ctrl0_reg;
                    O_HRDATA[acc_pkg::BIT_BUSY] = busy_reg;
                end
                acc_pkg::OFS_CTRL1:    O_HRDATA[7:0] = ctrl1_reg;
                acc_pkg::OFS_RES_HIGH: O_HRDATA[7:0] = view[15:8];
                acc_pkg::OFS_RES_LOW:  O_HRDATA[7:0] = view[7:0];
                acc_pkg::OFS_IRQ:      O_HRDATA[2:0] = irq_reg;
                default:               O_HRDATA = 32'h0000_0000;
            endcase
        end
        O_HREADYOUT = 1'b1;
        O_HRESP     = 1'b0;
    end

    // software register writes; the hardware flag set wins over a clear
    always_comb begin
        ctrl0_next   = ctrl0_reg;
        ctrl1_next   = ctrl1_reg;
        irq_next     = irq_reg;
        start_q_next = start_bit;
        if (wr_pend_reg) begin
            case (addr_reg)
                acc_pkg::OFS_CTRL0: begin
                    ctrl0_next                    = I_HWDATA[7:0];
                    ctrl0_next[acc_pkg::BIT_BUSY] = 1'b0;  // busy is read only
                end
                acc_pkg::OFS_CTRL1: ctrl1_next = I_HWDATA[7:0];
                acc_pkg::OFS_IRQ:   irq_next   = I_HWDATA[2:0];
                default: begin
                    ctrl0_next = ctrl0_reg;  // unmapped write ignored
                end
            endcase
        end
        if (done) begin
            irq_next[acc_pkg::BIT_FLAG] = 1'b1;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ctrl0_reg   <= acc_pkg::CTRL0_RST;
            ctrl1_reg   <= acc_pkg::CTRL1_RST;
            irq_reg     <= acc_pkg::IRQ_RST;
            start_q_reg <= 1'b0;
        end else begin
            ctrl0_reg   <= ctrl0_next;
            ctrl1_reg   <= ctrl1_next;
            irq_reg     <= irq_next;
            start_q_reg <= start_q_next;
        end
    end

    // conversion sequencer: sample for a few periods, then one bit of
    // successive approximation per period, msb first
    always_comb begin
        hold        = !power_bit || start_bit;
        launch      = start_q_reg && !start_bit;
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        bit_next    = bit_reg;
        sar_next    = sar_reg;
        result_next = result_reg;
        busy_next   = busy_reg;
        done        = 1'b0;
        if (hold) begin
            // a power-off or a start held high aborts any conversion
            state_next = acc_pkg::ST_IDLE;
            busy_next  = 1'b0;
            cnt_next   = 4'h0;
            sar_next   = '0;
        end else begin
            case (state_reg)
                acc_pkg::ST_IDLE: begin
                    if (launch) begin
                        state_next = acc_pkg::ST_SAMPLE;
                        busy_next  = 1'b1;
                        cnt_next   = 4'h0;
                        sar_next   = '0;
                    end
                end
                acc_pkg::ST_SAMPLE: begin
                    if (tick) begin
                        if (cnt_reg == 4'(acc_pkg::SAMPLE_TICKS - 1)) begin
                            state_next = acc_pkg::ST_CONVERT;
                            bit_next   = 4'(acc_pkg::CONVERT_TICKS - 1);
                        end else begin
                            cnt_next = cnt_reg + 4'h1;
                        end
                    end
                end
                acc_pkg::ST_CONVERT: begin
                    if (tick) begin
                        sar_next[bit_reg] = I_CMP_ABOVE;
                        if (bit_reg == 4'h0) begin
                            // last of the twelve periods: publish and finish
                            state_next  = acc_pkg::ST_IDLE;
                            result_next = sar_next;
                            busy_next   = 1'b0;
                            done        = 1'b1;
                        end else begin
                            bit_next = bit_reg - 4'h1;
                        end
                    end
                end
                default: begin
                    state_next = acc_pkg::ST_IDLE;
                    busy_next  = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            state_reg  <= acc_pkg::ST_IDLE;
            cnt_reg    <= 4'h0;
            bit_reg    <= 4'h0;
            sar_reg    <= '0;
            result_reg <= '0;
            busy_reg   <= 1'b0;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            bit_reg    <= bit_next;
            sar_reg    <= sar_next;
            result_reg <= result_next;
            busy_reg   <= busy_next;
        end
    end

    // analog controls; the trial level is the approximation with the bit
    // under test set, the half-step offset lives in the analog ladder
    always_comb begin
        O_ADC_POWER   = power_bit;
        O_ADC_RESET   = hold;
        O_ADC_SAMPLE  = (state_reg == acc_pkg::ST_SAMPLE);
        O_DAC_CODE    = '0;
        if (state_reg == acc_pkg::ST_CONVERT) begin
            O_DAC_CODE = sar_reg | (acc_pkg::RES_W'(1) << bit_reg);
        end
        O_INPUT_SRC   = ctrl1_reg[acc_pkg::SRC_LSB +: acc_pkg::SRC_W];
        O_EXT_CHANNEL = ctrl0_reg[acc_pkg::CHAN_LSB +: acc_pkg::CHAN_W];
        // an internal source cuts the pin off whatever channel is chosen
        O_EXT_CONNECT = power_bit && (O_INPUT_SRC == acc_pkg::SRC_EXTERNAL);
        O_VREF_SRC    = ctrl1_reg[acc_pkg::VREF_LSB +: acc_pkg::VREF_W];
        O_BUSY        = busy_reg;
        // level request, both enables needed; software clears the flag
        O_CONV_IRQ    = irq_reg[acc_pkg::BIT_FLAG] && irq_reg[acc_pkg::BIT_CIE]
                        && irq_reg[acc_pkg::BIT_GIE];
    end

endmodule : acc_top

/* File: acc_top_chk.sv */
`timescale 1ns/1ns
// port-level watcher of the converter controller
module acc_top_chk (
    // clock and reset
    input wire logic                       I_CLK,
    input wire logic                       I_RSTN,
    // bus side
    input wire logic                       I_HSEL,
    input wire logic [1:0]                 I_HTRANS,
    input wire logic                       I_HWRITE,
    input wire logic                       I_HREADY,
    input wire logic [31:0]                O_HRDATA,
    input wire logic                       O_HREADYOUT,
    input wire logic                       O_HRESP,
    // converter side
    input wire logic                       O_ADC_POWER,
    input wire logic                       O_ADC_RESET,
    input wire logic                       O_ADC_SAMPLE,
    input wire logic [acc_pkg::RES_W-1:0]  O_DAC_CODE,
    input wire logic [acc_pkg::SRC_W-1:0]  O_INPUT_SRC,
    input wire logic                       O_EXT_CONNECT,
    input wire logic                       O_BUSY
);
    logic rd_reg;   // a read data phase is under way
    logic rd_next;  // read address phase taken this cycle

    // track read data phases so idle read data can be policed
    always_comb begin
        rd_next = I_HSEL & I_HTRANS[1] & I_HREADY & ~I_HWRITE;
    end

    // register the phase tracker
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rd_reg <= 1'h0;
        end else begin
            rd_reg <= rd_next;
        end
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);

    // sampling lasts four ticks of at least one cycle each
    sequence s_sample4;
        O_ADC_SAMPLE [*4];
    endsequence
    // first trial of the approximation tests the top bit alone
    sequence s_first_trial;
        O_BUSY && (O_DAC_CODE == 12'h800);
    endsequence

    chk_bus_okay: assert property (O_HREADYOUT && !O_HRESP)
        else $error("bus slave stalled or answered with an error");
    chk_rd_idle: assert property (!rd_reg |-> O_HRDATA == 32'h0)
        else $error("read data driven outside a read data phase");
    chk_ext_connect: assert property (O_EXT_CONNECT == (O_ADC_POWER && O_INPUT_SRC == 3'h0))
        else $error("external channel connection does not follow power and source");
    chk_power_off: assert property (!O_ADC_POWER |-> O_ADC_RESET)
        else $error("converter not held off while powered down");
    chk_reset_abort: assert property (O_ADC_RESET |=> !O_BUSY)
        else $error("busy survived a converter reset");
    chk_sample_len: assert property ($rose(O_ADC_SAMPLE) |-> s_sample4)
        else $error("sampling shorter than four ticks");
    chk_sample_busy: assert property (O_ADC_SAMPLE |-> O_BUSY)
        else $error("sampling without busy");
    chk_trial_msb: assert property ($fell(O_ADC_SAMPLE) && O_BUSY |-> s_first_trial)
        else $error("first trial code is not the top bit");
    chk_code_busy: assert property (O_DAC_CODE != 12'h0 |-> O_BUSY && !O_ADC_SAMPLE)
        else $error("trial code outside the conversion phase");
endmodule : acc_top_chk

bind acc_top acc_top_chk u_chk (
    .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_HSEL(I_HSEL), .I_HTRANS(I_HTRANS),
    .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA),
    .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .O_ADC_POWER(O_ADC_POWER),
    .O_ADC_RESET(O_ADC_RESET), .O_ADC_SAMPLE(O_ADC_SAMPLE), .O_DAC_CODE(O_DAC_CODE),
    .O_INPUT_SRC(O_INPUT_SRC), .O_EXT_CONNECT(O_EXT_CONNECT), .O_BUSY(O_BUSY)
);

/* File: acc_top_test.sv */
`timescale 1ns/1ns
// self-checking bench for the converter controller
module acc_top_test;
    typedef struct { logic [7:0] ofs; logic [31:0] wd; logic [31:0] rd; } acc_row_t;
    logic        I_CLK, I_RSTN, I_HSEL, I_HWRITE, I_HREADY, I_CMP_ABOVE;  // bench drive
    logic [31:0] I_HADDR, I_HWDATA, O_HRDATA, rd;                         // bus words
    logic [1:0]  I_HTRANS, O_VREF_SRC;
    logic [2:0]  I_HSIZE, O_INPUT_SRC;
    logic [3:0]  O_EXT_CHANNEL;
    logic [11:0] O_DAC_CODE, vin;                                         // vin: analog input as a code
    logic        O_HREADYOUT, O_HRESP, O_ADC_POWER, O_ADC_RESET, O_ADC_SAMPLE, O_EXT_CONNECT, O_BUSY, O_CONV_IRQ;
    int          failures, n_tests, n;
    // register and unmapped offset cases: write, read back, expected word
    acc_row_t rows [8] = '{
        '{acc_pkg::OFS_CTRL1, 32'hffff_ffff, 32'h0000_00ff}, '{acc_pkg::OFS_CTRL1, 32'h0000_00a5, 32'h0000_00a5},
        '{acc_pkg::OFS_CTRL0, 32'hffff_ff7f, 32'h0000_003f}, '{acc_pkg::OFS_CTRL0, 32'h0000_005f, 32'h0000_001f},
        '{acc_pkg::OFS_IRQ, 32'hffff_fffb, 32'h0000_0003}, '{8'h14, 32'hffff_ffff, 32'h0000_0000},
        '{8'hfc, 32'h5a5a_5a5a, 32'h0000_0000}, '{acc_pkg::OFS_IRQ, 32'h0000_0000, 32'h0000_0000}};
    logic [7:0]  rst_ofs [5] = '{acc_pkg::OFS_CTRL0, acc_pkg::OFS_CTRL1, acc_pkg::OFS_RES_HIGH,
                                 acc_pkg::OFS_RES_LOW, acc_pkg::OFS_IRQ};
    // edge cases of the result: full scale, zero, around mid scale
    logic [11:0] vin_tab [8] = '{12'hfff, 12'h000, 12'h800, 12'h7ff, 12'h5a3, 12'h001, 12'hffe, 12'h3c6};

    // ideal comparator: the kept bit is set while the input reaches the trial
    assign I_CMP_ABOVE = (vin >= O_DAC_CODE);

    acc_top uut (
        .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_HSEL(I_HSEL), .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS),
        .I_HWRITE(I_HWRITE), .I_HSIZE(I_HSIZE), .I_HWDATA(I_HWDATA), .I_HREADY(I_HREADY),
        .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .I_CMP_ABOVE(I_CMP_ABOVE),
        .O_ADC_POWER(O_ADC_POWER), .O_ADC_RESET(O_ADC_RESET), .O_ADC_SAMPLE(O_ADC_SAMPLE),
        .O_DAC_CODE(O_DAC_CODE), .O_INPUT_SRC(O_INPUT_SRC), .O_EXT_CHANNEL(O_EXT_CHANNEL),
        .O_EXT_CONNECT(O_EXT_CONNECT), .O_VREF_SRC(O_VREF_SRC), .O_BUSY(O_BUSY), .O_CONV_IRQ(O_CONV_IRQ));

    // 25 MHz system clock
    initial begin
        I_CLK = 1'h0;
        forever #20 I_CLK = ~I_CLK;
    end

    task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk_word

    task automatic chk_bit(input string nm, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %b seen %b", nm, exp, got);
        end
    endtask : chk_bit

    // one single word transfer; read data lands in rd at the end of the data phase
    task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
        @(posedge I_CLK);
        I_HSEL   <= 1'h1;
        I_HTRANS <= 2'h2;
        I_HWRITE <= wr;
        I_HADDR  <= {24'h0, ofs};
        do @(posedge I_CLK); while (O_HREADYOUT !== 1'h1);
        I_HSEL   <= 1'h0;
        I_HTRANS <= 2'h0;
        I_HWDATA <= wd;
        do @(posedge I_CLK); while (O_HREADYOUT !== 1'h1);
        rd = O_HRDATA;
    endtask : bus

    // divider, then start high with power on, then start low
    task automatic launch(input logic [2:0] d, input logic fmt);
        bus(1'h1, acc_pkg::OFS_CTRL1, {29'h0, d});
        bus(1'h1, acc_pkg::OFS_CTRL0, {24'h0, 3'h5, fmt, 4'h0});
        bus(1'h1, acc_pkg::OFS_CTRL0, {24'h0, 3'h1, fmt, 4'h0});
    endtask : launch

    // time the busy window, then read the result in the chosen layout
    task automatic finish_conv(input logic [2:0] d, input logic fmt);
        do @(posedge I_CLK); while (O_BUSY !== 1'h1);
        n = 0;
        do begin
            @(posedge I_CLK);
            n++;
        end while (O_BUSY !== 1'h0);
        chk_word("conversion cycles", 32'(16 << d), 32'(n));
        bus(1'h0, acc_pkg::OFS_RES_HIGH, 32'h0);
        chk_word("result high", fmt ? {28'h0, vin[11:8]} : {24'h0, vin[11:4]}, rd);
        bus(1'h0, acc_pkg::OFS_RES_LOW, 32'h0);
        chk_word("result low", fmt ? {24'h0, vin[7:0]} : {24'h0, vin[3:0], 4'h0}, rd);
    endtask : finish_conv

    task automatic print_verdict;
        if (failures == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    // a hang ends the run well past the longest expected sequence
    initial begin
        repeat (20000) @(posedge I_CLK);
        failures++;
        print_verdict();
    end

    initial begin
        {I_RSTN, I_HSEL, I_HWRITE, I_HADDR, I_HTRANS, I_HWDATA} = '0;
        {I_HREADY, I_HSIZE, vin, failures, n_tests} = {1'h1, 3'h2, 12'h0, 32'h0, 32'h0};
        repeat (2) @(posedge I_CLK);
        chk_bit("reset holds converter", 1'h1, O_ADC_RESET);
        I_RSTN <= 1'h1;
        foreach (rst_ofs[i]) begin
            bus(1'h0, rst_ofs[i], 32'h0);
            chk_word("reset value", 32'h0, rd);
        end
        foreach (rows[i]) begin
            bus(1'h1, rows[i].ofs, rows[i].wd);
            bus(1'h0, rows[i].ofs, 32'h0);
            chk_word("register readback", rows[i].rd, rd);
        end
        // internal source 2, reference 3, channel 9, powered
        bus(1'h1, acc_pkg::OFS_CTRL1, 32'h59);
        bus(1'h1, acc_pkg::OFS_CTRL0, 32'h29);
        @(negedge I_CLK);
        chk_word("routing outputs", 32'h5ca, {O_INPUT_SRC, O_VREF_SRC, O_EXT_CHANNEL, O_EXT_CONNECT,
                 O_ADC_POWER, O_ADC_RESET});
        bus(1'h1, acc_pkg::OFS_CTRL1, 32'h19);
        @(negedge I_CLK);
        chk_bit("external connect", 1'h1, O_EXT_CONNECT);
        // a start pulse while powered down must not convert
        bus(1'h1, acc_pkg::OFS_CTRL0, 32'h89);
        bus(1'h1, acc_pkg::OFS_CTRL0, 32'h09);
        repeat (40) @(posedge I_CLK);
        chk_bit("busy when powered down", 1'h0, O_BUSY);
        chk_word("power off outputs", 32'h1, {O_EXT_CONNECT, O_ADC_POWER, O_ADC_RESET});
        // every divider code, both layouts, all four enable pairs
        for (int d = 0; d < 8; d++) begin
            vin <= vin_tab[d];
            bus(1'h1, acc_pkg::OFS_IRQ, {30'h0, 2'(d >> 1)});
            launch(3'(d), d[0]);
            finish_conv(3'(d), d[0]);
            @(negedge I_CLK);
            chk_bit("interrupt level", d[2] & d[1], O_CONV_IRQ);
            bus(1'h0, acc_pkg::OFS_IRQ, 32'h0);
            chk_word("flag after completion", {29'h0, 1'h1, 2'(d >> 1)}, rd);
            bus(1'h1, acc_pkg::OFS_IRQ, 32'h0);
            @(negedge I_CLK);
            chk_bit("interrupt cleared", 1'h0, O_CONV_IRQ);
        end
        // start raised mid-conversion aborts and holds, its fall restarts
        vin <= 12'h5a3;
        launch(3'h3, 1'h0);
        repeat (40) @(posedge I_CLK);
        bus(1'h1, acc_pkg::OFS_CTRL0, 32'ha0);
        repeat (40) @(posedge I_CLK);
        chk_bit("busy while start held", 1'h0, O_BUSY);
        bus(1'h1, acc_pkg::OFS_CTRL0, 32'h20);
        finish_conv(3'h3, 1'h0);
        // reset in mid-conversion clears everything
        launch(3'h2, 1'h1);
        repeat (20) @(posedge I_CLK);
        I_RSTN <= 1'h0;
        repeat (2) @(posedge I_CLK);
        chk_word("reset mid-run", 32'h1, {O_BUSY, O_ADC_POWER, O_ADC_RESET});
        I_RSTN <= 1'h1;
        bus(1'h0, acc_pkg::OFS_CTRL0, 32'h0);
        chk_word("control after reset", 32'h0, rd);
        print_verdict();
    end
endmodule : acc_top_test
